// *** sfc_flash_cmd.sv ***
// serial flash status, write latch, protection, deep sleep and id commands
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - status read answers while awake, even when busy
// - status output repeats until chip select rises
// - latch set command sets write latch
// - status write command clears write latch at select rise
// - latch commands act on select rise
// - latch clear command clears write latch
// - status write changes protect bits, busy while timed
// - locked and protect pin low ignores write
// - pin low lets lock only set
// - pin high lets all protect bits change
// - lock state checked at select rise
// - sleep command enters deep sleep at once, lowest power after delay
// - sleep command ignored while busy
// - asleep ignores all but release and id
// - release wakes, next command after recovery
// - id read repeats one byte after dummies
// - four-byte identifier sent in fixed order
// - identifier repeats; select rise ends it
// - write commands need whole-byte frame end
// - status write with two data bytes rejected
module sfc_flash_cmd #(
   parameter logic [7:0]  ID_CODE         = 8'hA5,          // arbitrary value
   parameter logic [31:0] JEDEC_ID        = 32'hC35A3CE1,   // arbitrary value
   parameter logic [7:0]  STATUS_WRITE_OP = 8'h01           // status_write_cmd code
) (
   input  wire logic                 sys_clk,     // system clock
   input  wire logic                 arst_n,      // asynchronous reset, active low
   input  wire logic                 linkClk,     // serial clock from the host
   input  wire logic                 csN,         // chip select, active low
   input  wire logic                 mosi,        // serial data in
   input  wire logic                 wpN,         // write protect pin, active low
   output var  logic                 miso,        // serial data out
   output var  logic                 misoOe,      // serial data out enable
   output var  sfc_pkg::sfc_status_t statusOut,   // live status byte
   output var  logic                 deepSleep,   // deep sleep in force
   output var  logic                 lowestPower  // entry delay has elapsed
);

   // ************************************************************
   // link side declarations
   // ************************************************************
   logic [2:0]          bitPos;    // bit within current byte
   logic [2:0]          byteNum;   // whole bytes this frame, saturating
   logic [1:0]          byteWrap;  // whole bytes this frame, wrapping
   logic [6:0]          shiftIn;   // partial incoming byte
   logic                started;   // a clock has been seen this frame
   logic                frameTog;  // toggles once per clocked frame
   sfc_pkg::sfc_frame_t frame;     // frame summary, survives select rise
   logic [8:0]          toLink;    // sleep flag and status, synchronised
   logic                sleepL;    // sleep flag in link domain
   logic [7:0]          statusL;   // status byte in link domain
   logic [1:0]          idSel;     // identifier byte being sent
   logic [7:0]          idByte;    // identifier byte picked

   // ************************************************************
   // system side declarations
   // ************************************************************
   logic [2:0]          toSys;       // select, protect pin, frame toggle
   logic                csS;         // select level, synchronised
   logic                wpLow;       // protect pin driven low
   logic                togS;        // frame toggle, synchronised
   logic                csPrev;      // select level one cycle back
   logic                frameSeen;   // last frame toggle handled
   logic                newFrame;    // clocked frame just closed
   logic                byteValid;   // frame had whole bytes only
   logic                acceptWrite; // status write takes effect
   logic                enterSleep;  // sleep command accepted
   logic                wakeUp;      // release command seen
   sfc_pkg::sfc_status_t wrData;     // status write data as fields
   logic [sfc_pkg::TMR_W-1:0] wrTimer;  // status write cycle counter
   logic [sfc_pkg::TMR_W-1:0] pwrTimer; // power delay counter
   sfc_pkg::sfc_power_t pwr;         // power state

   // ************************************************************
   // helper functions
   // ************************************************************
   // bit of a byte sent at a given position, msb first
   function automatic logic pickBit(input logic [7:0] b, input logic [2:0] pos);
      pickBit = b[3'h7 - pos];
   endfunction : pickBit

   // opcode match of the closed frame
   function automatic logic isOp(input sfc_pkg::sfc_frame_t f, input logic [7:0] op);
      isOp = (f.bytes != 3'h0) && (f.opcode == op);
   endfunction : isOp

   // ************************************************************
   // link domain: bit and byte counting
   // ************************************************************
   // counters restart with every frame; select high holds them cleared
   always_ff @(posedge linkClk or posedge csN) begin
      if (csN) begin
         bitPos   <= 3'h0;
         byteNum  <= 3'h0;
         byteWrap <= 2'h0;
         shiftIn  <= 7'h00;
         started  <= 1'b0;
      end else begin
         bitPos  <= bitPos + 3'h1;
         shiftIn <= {shiftIn[5:0], mosi};
         started <= 1'b1;
         // a byte completes on this edge
         if (bitPos == sfc_pkg::BIT_LAST) begin
            byteWrap <= byteWrap + 2'h1;
            if (byteNum != sfc_pkg::BYTE_SAT) begin
               byteNum <= byteNum + 3'h1;
            end
         end
      end
   end

   // ************************************************************
   // link domain: frame summary for the system side
   // ************************************************************
   // not cleared by select so the system side can read it afterwards
   always_ff @(posedge linkClk or negedge arst_n) begin
      if (!arst_n) begin
         frame    <= '0;
         frameTog <= 1'b0;
      end else begin
         frame.aligned <= (bitPos == sfc_pkg::BIT_LAST);
         // first edge of a frame announces a new frame
         if (!started) begin
            frameTog <= ~frameTog;
         end
         if (bitPos == sfc_pkg::BIT_LAST) begin
            frame.bytes <= (byteNum == sfc_pkg::BYTE_SAT) ? byteNum : byteNum + 3'h1;
            if (byteNum == 3'h0) begin
               frame.opcode <= {shiftIn, mosi};
            end
            if (byteNum == 3'h1) begin
               frame.data <= {shiftIn, mosi};
            end
         end else if (!started) begin
            frame.bytes <= 3'h0;  // stale opcode is never acted on
         end
      end
   end

   // ************************************************************
   // link domain: status and sleep flag crossing
   // ************************************************************
   sfc_sync2 #(
      .W (9)
   ) u_syncLink (
      .clk    (linkClk),
      .arst_n (arst_n),
      .d      ({deepSleep, statusOut}),
      .q      (toLink)
   );

   assign sleepL  = toLink[8];
   assign statusL = toLink[7:0];

   // identifier byte: first byte after the command is the first id byte
   assign idSel  = byteWrap - 2'h1;
   assign idByte = JEDEC_ID[{~idSel, 3'h7}-:8];

   // ************************************************************
   // link domain: serial output on falling edges
   // ************************************************************
   // select rising ends any output at once
   always_ff @(negedge linkClk or posedge csN) begin
      if (csN) begin
         miso   <= 1'b0;
         misoOe <= 1'b0;
      end else begin
         miso   <= 1'b0;
         misoOe <= 1'b0;
         if (byteNum != 3'h0) begin
            case (frame.opcode)
               // live status, busy or not, repeats every byte
               sfc_pkg::OP_STATUS_READ: begin
                  if (!sleepL) begin
                     misoOe <= 1'b1;
                     miso   <= pickBit(statusL, bitPos);
                  end
               end
               // one-byte id after three dummy bytes, also when asleep
               sfc_pkg::OP_RELEASE_READ_ID: begin
                  if (byteNum >= sfc_pkg::ID_DUMMY_END) begin
                     misoOe <= 1'b1;
                     miso   <= pickBit(ID_CODE, bitPos);
                  end
               end
               // four-byte identifier, repeating
               sfc_pkg::OP_JEDEC_ID: begin
                  if (!sleepL) begin
                     misoOe <= 1'b1;
                     miso   <= pickBit(idByte, bitPos);
                  end
               end
               default: begin
                  misoOe <= 1'b0;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // system domain: pin and frame crossing
   // ************************************************************
   sfc_sync2 #(
      .W (3)
   ) u_syncSys (
      .clk    (sys_clk),
      .arst_n (arst_n),
      .d      ({csN, wpN, frameTog}),
      .q      (toSys)
   );

   assign csS   = toSys[2];
   assign wpLow = ~toSys[1];
   assign togS  = toSys[0];

   // select edge and frame handshake
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         csPrev    <= 1'b0;
         frameSeen <= 1'b0;
      end else begin
         csPrev <= csS;
         if (csS && !csPrev) begin
            frameSeen <= togS;
         end
      end
   end

   // commands act only when select returns high
   assign newFrame  = csS && !csPrev && (togS != frameSeen);
   assign byteValid = frame.aligned && (frame.bytes != 3'h0);
   assign wrData    = sfc_pkg::sfc_status_t'(frame.data);

   // status write accepted: one data byte, latch set, idle, not locked with pin low
   assign acceptWrite = newFrame && (pwr == sfc_pkg::PWR_AWAKE)
                        && (frame.opcode == STATUS_WRITE_OP)
                        && frame.aligned
                        && (frame.bytes == sfc_pkg::WRITE_BYTES)
                        && statusOut.writeLatch && !statusOut.busy
                        && !(wpLow && statusOut.protectLock);

   // sleep accepted only when no internal cycle runs
   assign enterSleep = newFrame && (pwr == sfc_pkg::PWR_AWAKE) && byteValid
                       && isOp(frame, sfc_pkg::OP_DEEP_SLEEP)
                       && !statusOut.busy;

   // release or id read leaves deep sleep
   assign wakeUp = newFrame && isOp(frame, sfc_pkg::OP_RELEASE_READ_ID);

   // ************************************************************
   // system domain: status write timer
   // ************************************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrTimer <= '0;
      end else if (acceptWrite) begin
         wrTimer <= sfc_pkg::STATUS_WRITE_CYC;
      end else if (wrTimer != '0) begin
         wrTimer <= wrTimer - sfc_pkg::TMR_W'(1);
      end
   end

   // ************************************************************
   // system domain: status register
   // ************************************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         statusOut <= sfc_pkg::sfc_status_t'(sfc_pkg::STATUS_RST);
      end else begin
         // self-timed cycle over
         if (wrTimer == sfc_pkg::TMR_W'(1)) begin
            statusOut.busy <= 1'b0;
         end
         if (newFrame && (pwr == sfc_pkg::PWR_AWAKE)) begin
            if (byteValid && isOp(frame, sfc_pkg::OP_WRITE_LATCH_SET)) begin
               statusOut.writeLatch <= 1'b1;
            end
            if (byteValid && isOp(frame, sfc_pkg::OP_WRITE_LATCH_CLR)) begin
               statusOut.writeLatch <= 1'b0;
            end
            if (isOp(frame, STATUS_WRITE_OP)) begin
               statusOut.writeLatch <= 1'b0;
            end
         end
         // only protect fields change; latch and busy stay read only
         if (acceptWrite) begin
            statusOut.blockProtect <= wrData.blockProtect;
            statusOut.topBottom    <= wrData.topBottom;
            statusOut.busy         <= 1'b1;
            if (wpLow) begin
               statusOut.protectLock <= statusOut.protectLock | wrData.protectLock;
            end else begin
               statusOut.protectLock <= wrData.protectLock;
            end
         end
      end
   end

   // ************************************************************
   // system domain: power state
   // ************************************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pwr      <= sfc_pkg::PWR_AWAKE;
         pwrTimer <= '0;
      end else begin
         case (pwr)
            // normal standby
            sfc_pkg::PWR_AWAKE: begin
               if (enterSleep) begin
                  pwr      <= sfc_pkg::PWR_ENTERING;
                  pwrTimer <= sfc_pkg::SLEEP_ENTRY_CYC;
               end
            end
            // asleep, waiting for lowest power
            sfc_pkg::PWR_ENTERING: begin
               if (wakeUp) begin
                  pwr      <= sfc_pkg::PWR_WAKING;
                  pwrTimer <= sfc_pkg::WAKE_RECOVERY_CYC;
               end else if (pwrTimer == sfc_pkg::TMR_W'(1)) begin
                  pwr      <= sfc_pkg::PWR_ASLEEP;
                  pwrTimer <= '0;
               end else begin
                  pwrTimer <= pwrTimer - sfc_pkg::TMR_W'(1);
               end
            end
            // lowest power, only release or id read is heard
            sfc_pkg::PWR_ASLEEP: begin
               if (wakeUp) begin
                  pwr      <= sfc_pkg::PWR_WAKING;
                  pwrTimer <= sfc_pkg::WAKE_RECOVERY_CYC;
               end
            end
            // recovering, commands still ignored
            sfc_pkg::PWR_WAKING: begin
               if (pwrTimer == sfc_pkg::TMR_W'(1)) begin
                  pwr      <= sfc_pkg::PWR_AWAKE;
                  pwrTimer <= '0;
               end else begin
                  pwrTimer <= pwrTimer - sfc_pkg::TMR_W'(1);
               end
            end
            default: begin
               pwr      <= sfc_pkg::PWR_AWAKE;
               pwrTimer <= '0;
            end
         endcase
      end
   end

   // ************************************************************
   // system domain: power outputs
   // ************************************************************
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         deepSleep   <= 1'b0;
         lowestPower <= 1'b0;
      end else begin
         deepSleep   <= (pwr != sfc_pkg::PWR_AWAKE);
         lowestPower <= (pwr == sfc_pkg::PWR_ASLEEP);
      end
   end

endmodule : sfc_flash_cmd

`default_nettype wire

// *** sfc_flash_cmd_properties.sv ***
// concurrent checks on the ports of the flash command block
`timescale 1ns/1ps
`default_nettype none

module sfc_flash_cmd_properties (
   input wire logic                 sys_clk,     // system clock
   input wire logic                 arst_n,      // reset, active low
   input wire logic                 csN,         // chip select, active low
   input wire logic                 wpN,         // write protect pin, active low
   input wire logic                 miso,        // serial data out
   input wire logic                 misoOe,      // serial data out enable
   input wire sfc_pkg::sfc_status_t statusOut,   // live status byte
   input wire logic                 deepSleep,   // deep sleep in force
   input wire logic                 lowestPower  // entry delay elapsed
);
   // all checks run on the system clock
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   oe_idle_a: assert property (csN |-> !misoOe)
      else $error("output enabled while deselected");
   miso_quiet_a: assert property (!misoOe |-> !miso)
      else $error("data out driven while disabled");
   spare_zero_a: assert property (!statusOut.spare)
      else $error("reserved status bit set");
   power_order_a: assert property (lowestPower |-> deepSleep)
      else $error("lowest power without deep sleep");
   entry_delay_a: assert property ($rose(lowestPower) |-> $past(deepSleep, 250))
      else $error("lowest power reached too early");
   busy_span_a: assert property ($rose(statusOut.busy) |->
      ##[95:105] $fell(statusOut.busy))
      else $error("status write time wrong");
   latch_drop_a: assert property ($rose(statusOut.busy) |-> !statusOut.writeLatch)
      else $error("write latch kept after status write");
   protect_when_a: assert property (!$stable({statusOut.protectLock, statusOut.topBottom,
      statusOut.blockProtect}) |-> $rose(statusOut.busy))
      else $error("protect bits changed outside a status write");
   lock_hold_a: assert property ($fell(statusOut.protectLock) |-> wpN)
      else $error("lock cleared while protect pin low");
   sleep_latch_a: assert property ($rose(statusOut.writeLatch) |-> !deepSleep)
      else $error("latch set while asleep");
endmodule : sfc_flash_cmd_properties

`default_nettype wire

// *** sfc_flash_cmd_tb.sv ***
// self-checking bench for the flash status and id command block
`timescale 1ns/1ps
`default_nettype none

module sfc_flash_cmd_tb;
   localparam logic [7:0]  ID_V  = 8'h3C;         // arbitrary value
   localparam logic [31:0] JID_V = 32'h1E2D4B96;  // arbitrary value
   logic                 sys_clk, arst_n, wpN;     // bench driven inputs
   logic                 linkClk, csN, mosi;       // host model outputs
   logic                 miso, misoOe, deepSleep, lowestPower;
   sfc_pkg::sfc_status_t statusOut;               // live status byte
   logic [71:0]          rx;                      // last frame's capture
   int                   num_errors = 0;
   int                   tests_run  = 0;

   sfc_flash_cmd #(.ID_CODE(ID_V), .JEDEC_ID(JID_V), .STATUS_WRITE_OP(8'h01)) i_dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .linkClk(linkClk), .csN(csN), .mosi(mosi),
      .wpN(wpN), .miso(miso), .misoOe(misoOe), .statusOut(statusOut),
      .deepSleep(deepSleep), .lowestPower(lowestPower));
   sfc_spi_host i_host (.linkClk(linkClk), .csN(csN), .mosi(mosi), .miso(miso));

   // 100 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // compare and count
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // one frame: opcode, following bits, total bit count
   task automatic cmd(input logic [7:0] op, input logic [63:0] arg, input int nb);
      i_host.xfer({op, arg}, nb, rx);
   endtask : cmd

   // status read over the link
   task automatic readStatus(input logic [7:0] exp);
      cmd(8'h05, 64'h0, 16);
      chk("status", 64'(exp), 64'(rx[7:0]));
   endtask : readStatus

   // latch set, status write of nb bits, then wait out the timed cycle
   task automatic writeStatus(input logic [15:0] d, input int nb);
      cmd(8'h06, 64'h0, 8);
      cmd(8'h01, {d, 48'h0}, nb);
      #1100;
   endtask : writeStatus

   // verdict and end of run
   task automatic complete_run;
      if (num_errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   // watchdog
   initial begin
      #100000;
      num_errors++;
      complete_run();
   end

   // main sequence
   initial begin
      arst_n = 1'b0;
      wpN    = 1'b1;
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk) arst_n = 1'b1;
      chk("reset", 64'(8'h00), 64'(statusOut));
      readStatus(8'h00);
      cmd(8'h06, 64'h0, 8);
      readStatus(8'h02);
      cmd(8'h04, 64'h0, 8);
      readStatus(8'h00);
      cmd(8'h06, 64'h0, 9);
      readStatus(8'h00);
      cmd(8'h06, 64'h0, 8);
      cmd(8'h01, 64'hBF00000000000000, 16);
      readStatus(8'hBD);
      cmd(8'hB9, 64'h0, 8);
      chk("sleep busy", 64'h0, 64'(deepSleep));
      #1100;
      readStatus(8'hBC);
      @(negedge sys_clk) wpN = 1'b0;
      writeStatus(16'h0000, 16);
      readStatus(8'hBC);
      @(negedge sys_clk) wpN = 1'b1;
      writeStatus(16'h0000, 16);
      readStatus(8'h00);
      @(negedge sys_clk) wpN = 1'b0;
      writeStatus(16'h9C00, 16);
      readStatus(8'h9C);
      @(negedge sys_clk) wpN = 1'b1;
      writeStatus(16'h0000, 24);
      readStatus(8'h9C);
      writeStatus(16'h0000, 16);
      readStatus(8'h00);
      cmd(8'h9F, 64'h0, 72);
      chk("jedec", {JID_V, JID_V}, rx[63:0]);
      chk("oe after frame", 64'h0, 64'(misoOe));
      cmd(8'hAB, 64'h0, 48);
      chk("id", 64'({ID_V, ID_V}), 64'(rx[15:0]));
      cmd(8'hB9, 64'h0, 8);
      chk("asleep", 64'h1, 64'(deepSleep));
      chk("not lowest", 64'h0, 64'(lowestPower));
      #3100;
      chk("lowest", 64'h1, 64'(lowestPower));
      cmd(8'h06, 64'h0, 8);
      readStatus(8'h00);
      cmd(8'h9F, 64'h0, 40);
      chk("jedec asleep", 64'h0, 64'(rx[31:0]));
      cmd(8'hAB, 64'h0, 8);
      chk("waking", 64'h0, 64'(lowestPower));
      #3100;
      chk("awake", 64'h0, 64'(deepSleep));
      cmd(8'h06, 64'h0, 8);
      readStatus(8'h02);
      complete_run();
   end
endmodule : sfc_flash_cmd_tb

bind sfc_flash_cmd sfc_flash_cmd_properties i_props (.sys_clk(sys_clk), .arst_n(arst_n),
   .csN(csN), .wpN(wpN), .miso(miso), .misoOe(misoOe), .statusOut(statusOut),
   .deepSleep(deepSleep), .lowestPower(lowestPower));

`default_nettype wire

// *** sfc_pkg.sv ***
// constants and types shared by the serial flash status and id command block
package sfc_pkg;

   // ************************************************************
   // clock rate and timing figures
   // ************************************************************
   localparam int unsigned SYS_CLK_MHZ            = 100;   // system clock rate
   localparam int unsigned STATUS_WRITE_TIME_NS   = 1000;  // self-timed status write
   localparam int unsigned SLEEP_ENTRY_DELAY_NS   = 3000;  // entry into lowest power
   localparam int unsigned WAKE_RECOVERY_DELAY_NS = 3000;  // release back to standby

   localparam int TMR_W = 12;  // width of every delay counter

   // least times round up to whole cycles
   localparam logic [TMR_W-1:0] STATUS_WRITE_CYC =
      TMR_W'((STATUS_WRITE_TIME_NS * SYS_CLK_MHZ + 999) / 1000);
   localparam logic [TMR_W-1:0] SLEEP_ENTRY_CYC =
      TMR_W'((SLEEP_ENTRY_DELAY_NS * SYS_CLK_MHZ + 999) / 1000);
   localparam logic [TMR_W-1:0] WAKE_RECOVERY_CYC =
      TMR_W'((WAKE_RECOVERY_DELAY_NS * SYS_CLK_MHZ + 999) / 1000);

   // ************************************************************
   // command codes
   // ************************************************************
   localparam logic [7:0] OP_STATUS_READ      = 8'h05;  // status_read_cmd
   localparam logic [7:0] OP_WRITE_LATCH_SET  = 8'h06;  // write_latch_set_cmd
   localparam logic [7:0] OP_WRITE_LATCH_CLR  = 8'h04;  // write_latch_clear_cmd
   localparam logic [7:0] OP_DEEP_SLEEP       = 8'hB9;  // deep_sleep_cmd
   localparam logic [7:0] OP_RELEASE_READ_ID  = 8'hAB;  // release or one-byte id
   localparam logic [7:0] OP_JEDEC_ID         = 8'h9F;  // four-byte identifier

   // ************************************************************
   // frame counting
   // ************************************************************
   localparam logic [2:0] BIT_LAST     = 3'h7;  // last bit of a byte
   localparam logic [2:0] BYTE_SAT     = 3'h7;  // byte counter saturates here
   localparam logic [2:0] ID_DUMMY_END = 3'h4;  // command plus three dummy bytes
   localparam logic [2:0] WRITE_BYTES  = 3'h2;  // command plus one data byte

   // ************************************************************
   // status byte layout and reset value
   // ************************************************************
   typedef struct packed {
      logic       protectLock;   // protect_lock_bit
      logic       spare;         // always zero
      logic       topBottom;     // top_bottom_select
      logic [2:0] blockProtect;  // block_protect_bit2..0
      logic       writeLatch;    // write-enable latch, read only
      logic       busy;          // internal cycle running, read only
   } sfc_status_t;

   localparam logic [7:0] STATUS_RST = 8'h00;  // status after reset

   // summary of one chip-select frame, handed from link to system side
   typedef struct packed {
      logic [7:0] opcode;   // first byte
      logic [7:0] data;     // second byte
      logic [2:0] bytes;    // whole bytes seen, saturating
      logic       aligned;  // frame ended on a byte boundary
   } sfc_frame_t;

   // power states
   typedef enum logic [1:0] {
      PWR_AWAKE,
      PWR_ENTERING,
      PWR_ASLEEP,
      PWR_WAKING
   } sfc_power_t;

endpackage : sfc_pkg

// *** sfc_spi_host.sv ***
// serial host model: frames, clocks and captures returned bits
`timescale 1ns/1ps
`default_nettype none

module sfc_spi_host (
   output var  logic linkClk,  // serial clock, still outside frames
   output var  logic csN,      // chip select, active low
   output var  logic mosi,     // serial data to the device
   input  wire logic miso      // serial data from the device
);
   // idle levels at time zero
   initial begin
      linkClk = 1'b0;
      csN     = 1'b1;
      mosi    = 1'b0;
   end

   // one frame: nb bits of tx, msb first, select held low throughout
   task automatic xfer(input logic [71:0] tx, input int nb, output logic [71:0] rx);
      rx  = '0;
      csN = 1'b0;
      #5;
      for (int i = 0; i < nb; i++) begin
         mosi = tx[71-i];
         #3;
         linkClk = 1'b1;
         rx = {rx[70:0], miso};
         #3;
         linkClk = 1'b0;
      end
      #5;
      csN  = 1'b1;
      mosi = ~mosi;
      #80;
   endtask : xfer
endmodule : sfc_spi_host

`default_nettype wire

// *** sfc_sync2.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module sfc_sync2 #(
   parameter int W = 1  // number of independent levels
) (
   input  wire logic         clk,     // destination clock
   input  wire logic         arst_n,  // asynchronous reset, active low
   input  wire logic [W-1:0] d,       // level from another domain
   output var  logic [W-1:0] q        // synchronised level
);

   logic [W-1:0] meta;  // first stage, read only by the second

   // ************************************************************
   // two stages
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : sfc_sync2

`default_nettype wire
